// *** src/iod_pkg.sv ***
// constants, types and word classifier for the operand field decoder
// assumes 16-bit instruction words, a 4K data space and a 32-bit apb slave
//
// How it works
// - a=0 maps file address into access ram ignoring bank; a=1 uses bank selector
// - bit operations carry a 3-bit index picking bit 0 to 7 of the register
// - d=0 sends result to working accumulator, d=1 back to file register
// - single-word file field is an 8-bit address or a 2-bit pointer designator
// - two-word move takes a full 12-bit source address, bank selector unused
// - two-word move takes a full 12-bit destination address from word two
// - s=1 saves or restores shadow registers on call or return; s=0 leaves them
// - table mode picks none, post-inc, post-dec or pre-inc, table ops only
// - table pointer is 21 bits into program memory; one byte via table latch
// - literals are 8, 12 or 20 bits wide depending on the instruction
// - relative branches use a two's complement offset; call and goto direct
// - don't-care bits never change the decode; zero is the preferred form
// - five alu flags kept: carry, nibble carry, zero, signed wrap, negative
// - indexed form adds 7-bit source and destination offsets to a pointer
// - a second word, top four bits ones, executed alone acts as no-operation
// - one instruction cycle is four clock phases; branches other than conditional ones add a cycle
package iod_pkg;
   localparam int unsigned IOD_ADDR_W = 12;
   localparam int unsigned IOD_TP_W = 21;
   localparam int unsigned IOD_NUM_PTR = 3;
   localparam logic [7:0] IOD_ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] IOD_LOW_BANK = 4'h0;
   localparam logic [3:0] IOD_HIGH_BANK = 4'hF;
   localparam logic [1:0] IOD_Q_LAST = 2'h3;
   localparam logic [1:0] IOD_CYC_ONE = 2'h1;
   localparam logic [1:0] IOD_CYC_TWO = 2'h2;
   localparam logic [1:0] IOD_TM_NONE = 2'h0;
   localparam logic [1:0] IOD_TM_POSTINC = 2'h1;
   localparam logic [1:0] IOD_TM_POSTDEC = 2'h2;
   localparam logic [1:0] IOD_TM_PREINC = 2'h3;
   localparam logic [7:0] IOD_OFF_CTRL = 8'h00;
   localparam logic [7:0] IOD_OFF_FLAGS = 8'h04;
   localparam logic [7:0] IOD_OFF_TABLE_POINTER = 8'h08;
   localparam logic [7:0] IOD_OFF_TBLLAT = 8'h0C;
   localparam logic [7:0] IOD_OFF_IPTR0 = 8'h10;
   localparam logic [7:0] IOD_OFF_STATE = 8'h1C;
   localparam logic [3:0] IOD_RST_BANK = 4'h0;
   localparam logic [4:0] IOD_RST_FLAGS = 5'h00;
   localparam logic [20:0] IOD_RST_TP = 21'h000000;
   localparam logic [7:0] IOD_RST_TLAT = 8'h00;
   localparam logic [11:0] IOD_RST_PTR = 12'h000;
   // flag bit positions
   localparam int unsigned IOD_FL_CARRY = 0;
   localparam int unsigned IOD_FL_NIBBLE = 1;
   localparam int unsigned IOD_FL_ZERO = 2;
   localparam int unsigned IOD_FL_WRAP = 3;
   localparam int unsigned IOD_FL_NEG = 4;

   typedef enum logic [3:0] {
      CL_NOP, CL_BYTE, CL_BIT, CL_LIT, CL_LFSR, CL_MOVFF, CL_IDX, CL_BRA,
      CL_BCC, CL_CALL, CL_GOTO, CL_RET, CL_TBLRD, CL_TBLWT, CL_SECOND
   } iod_class_type;

   // wildcards keep don't-care bits out of the decision
   function automatic iod_class_type iod_classify(input logic [15:0] w);
      casez (w)
         16'b0000_0000_0000_10??: return CL_TBLRD;
         16'b0000_0000_0000_11??: return CL_TBLWT;
         16'b0000_0000_0001_001?: return CL_RET;
         16'b0000_0000_????_????: return CL_NOP;
         16'b0000_1???_????_????: return CL_LIT;
         16'b0???_????_????_????: return (w[15:12] == 4'h7) ? CL_BIT : CL_BYTE;
         16'b10??_????_????_????: return CL_BIT;
         16'b1011_????_????_????: return CL_BIT;
         16'b1100_????_????_????: return CL_MOVFF;
         16'b1101_????_????_????: return CL_BRA;
         16'b1110_0???_????_????: return CL_BCC;
         16'b1110_110?_????_????: return CL_CALL;
         16'b1110_1110_????_????: return CL_LFSR;
         16'b1110_1011_????_????: return CL_IDX;
         16'b1110_1111_????_????: return CL_GOTO;
         16'b1111_????_????_????: return CL_SECOND;
         default: return CL_NOP;
      endcase
   endfunction

   function automatic logic iod_is_double(input iod_class_type c);
      return (c == CL_MOVFF) || (c == CL_IDX) || (c == CL_CALL) ||
             (c == CL_GOTO) || (c == CL_LFSR);
   endfunction
endpackage

// *** src/iod_field_if.sv ***
// interface: words in, extracted operand fields out
// assumes the requester holds words stable while fields are read
`timescale 1ns/1ps
`default_nettype none
interface iod_field_if import iod_pkg::*; ();
   logic [15:0] first_word;
   logic [15:0] second_word;
   logic [3:0] bank;
   logic [11:0] index_base;
   iod_class_type cls;
   logic [11:0] src_addr;
   logic [11:0] dst_addr;
   logic to_file;
   logic [2:0] bit_idx;
   logic [19:0] literal;
   logic [1:0] ptr_sel;
   logic [20:0] target;
   logic rel;
   logic shadow;
   logic [1:0] tmode;
   logic [1:0] cycles;
   modport requester (output first_word, second_word, bank, index_base,
      input cls, src_addr, dst_addr, to_file, bit_idx, literal, ptr_sel,
      target, rel, shadow, tmode, cycles);
   modport decoder (input first_word, second_word, bank, index_base,
      output cls, src_addr, dst_addr, to_file, bit_idx, literal, ptr_sel,
      target, rel, shadow, tmode, cycles);
endinterface
`default_nettype wire

// *** src/iod_fields.sv ***
// combinational operand field extraction from one or two words
// assumes second_word is only meaningful for double-word classes
`timescale 1ns/1ps
`default_nettype none
module iod_fields import iod_pkg::*; #(
   parameter logic [7:0] ACCESS_SPLIT = IOD_ACCESS_SPLIT
) (
   iod_field_if.decoder fld
);
   logic [15:0] w1;
   logic [15:0] w2;
   assign w1 = fld.first_word;
   assign w2 = fld.second_word;

   function automatic logic [11:0] map_file(input logic acc, input logic [3:0] bk,
                                            input logic [7:0] f);
      if (acc)
         return {bk, f};
      return (f < ACCESS_SPLIT) ? {IOD_LOW_BANK, f} : {IOD_HIGH_BANK, f};
   endfunction

   always_comb begin
      fld.cls = iod_classify(w1);
      fld.src_addr = 12'h000;
      fld.dst_addr = 12'h000;
      fld.to_file = 1'b0;
      fld.bit_idx = 3'h0;
      fld.literal = 20'h00000;
      fld.ptr_sel = 2'h0;
      fld.target = 21'h000000;
      fld.rel = 1'b0;
      fld.shadow = 1'b0;
      fld.tmode = IOD_TM_NONE;
      fld.cycles = iod_is_double(fld.cls) ? IOD_CYC_TWO : IOD_CYC_ONE;
      case (fld.cls)
         CL_BYTE: begin
            fld.src_addr = map_file(w1[8], fld.bank, w1[7:0]);
            fld.to_file = w1[9];
         end
         CL_BIT: begin
            fld.src_addr = map_file(w1[8], fld.bank, w1[7:0]);
            fld.bit_idx = w1[11:9];
            fld.to_file = 1'b1;
         end
         CL_LIT: fld.literal = {12'h000, w1[7:0]};
         CL_LFSR: begin
            fld.ptr_sel = w1[5:4];
            fld.literal = {8'h00, w1[3:0], w2[7:0]};
         end
         CL_MOVFF: begin
            fld.src_addr = w1[11:0];
            fld.dst_addr = w2[11:0];
         end
         CL_IDX: begin
            fld.src_addr = fld.index_base + {5'h00, w1[6:0]};
            fld.dst_addr = fld.index_base + {5'h00, w2[6:0]};
         end
         CL_BRA: begin
            fld.target = {{10{w1[10]}}, w1[10:0]};
            fld.rel = 1'b1;
            fld.cycles = IOD_CYC_TWO;
         end
         CL_BCC: begin
            fld.target = {{13{w1[7]}}, w1[7:0]};
            fld.rel = 1'b1;
         end
         CL_CALL, CL_GOTO: begin
            fld.literal = {w2[11:0], w1[7:0]};
            fld.target = {1'b0, w2[11:0], w1[7:0]};
            fld.shadow = (fld.cls == CL_CALL) && w1[8];
         end
         CL_RET: begin
            fld.shadow = w1[0];
            fld.cycles = IOD_CYC_TWO;
         end
         CL_TBLRD, CL_TBLWT: fld.tmode = w1[1:0];
         default: fld.cycles = IOD_CYC_ONE;
      endcase
   end
endmodule
`default_nettype wire

// *** src/iod_decoder.sv ***
// operand field decoder top: fetch port, registered controls, apb registers
// assumes fetch stage and datapath share clk_sys; apb master on clk_sys too
`timescale 1ns/1ps
`default_nettype none
module iod_decoder import iod_pkg::*; #(
   parameter logic [7:0] ACCESS_SPLIT = IOD_ACCESS_SPLIT
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   output logic fetch_ready,
   input wire logic [7:0] tbl_rdata,
   input wire logic [4:0] alu_flag_we,
   input wire logic [4:0] alu_flag_in,
   output logic [4:0] alu_flags,
   output logic dec_valid,
   output logic [15:0] dec_opcode,
   output logic [3:0] dec_class,
   output logic [11:0] dec_src_addr,
   output logic [11:0] dec_dst_addr,
   output logic dec_to_file,
   output logic [2:0] dec_bit_idx,
   output logic [19:0] dec_literal,
   output logic [20:0] dec_target,
   output logic dec_rel,
   output logic [1:0] dec_cycles,
   output logic dec_nop,
   output logic shadow_save,
   output logic shadow_restore,
   output logic tbl_rd,
   output logic tbl_wr,
   output logic [20:0] tbl_addr,
   output logic [7:0] tbl_wdata
);
   if (ACCESS_SPLIT == 8'h00) begin : g_bad_split
      $error("access split must leave at least one low ram address");
   end

   typedef enum {ST_FIRST, ST_SECOND} iod_state_type;

   iod_field_if fld ();
   iod_fields #(.ACCESS_SPLIT(ACCESS_SPLIT)) u_fields (.fld(fld));

   iod_state_type st;
   iod_state_type next_st;
   logic [1:0] q;
   logic [1:0] next_q;
   logic [15:0] held;
   logic [15:0] next_held;
   logic [3:0] bank;
   logic [3:0] next_bank;
   logic [4:0] next_alu_flags;
   logic [20:0] tptr;
   logic [20:0] next_tptr;
   logic [7:0] tlat;
   logic [7:0] next_tlat;
   logic [11:0] iptr [IOD_NUM_PTR];
   logic [11:0] next_iptr [IOD_NUM_PTR];
   logic tbl_pend;
   logic next_tbl_pend;
   logic issue;
   logic bus_wr;
   logic [31:0] rd_mux;
   logic next_fetch_ready;
   logic next_dec_valid;
   logic [15:0] next_dec_opcode;
   logic [3:0] next_dec_class;
   logic [11:0] next_dec_src_addr;
   logic [11:0] next_dec_dst_addr;
   logic next_dec_to_file;
   logic [2:0] next_dec_bit_idx;
   logic [19:0] next_dec_literal;
   logic [20:0] next_dec_target;
   logic next_dec_rel;
   logic [1:0] next_dec_cycles;
   logic next_dec_nop;
   logic next_shadow_save;
   logic next_shadow_restore;
   logic next_tbl_rd;
   logic next_tbl_wr;
   logic [20:0] next_tbl_addr;
   logic [7:0] next_tbl_wdata;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   function automatic logic reg_hit(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= IOD_OFF_STATE);
   endfunction

   // word pair into the extractor; first word is held while waiting for word two
   assign fld.first_word = (st == ST_SECOND) ? held : instr_word;
   assign fld.second_word = instr_word;
   assign fld.bank = bank;
   assign fld.index_base = iptr[IOD_NUM_PTR-1];

   // apb: one wait state, write lands on the edge that samples pready high
   assign bus_wr = psel && penable && pready && pwrite && reg_hit(paddr);

   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         IOD_OFF_CTRL: rd_mux = {28'h0000000, bank};
         IOD_OFF_FLAGS: rd_mux = {27'h0000000, alu_flags};
         IOD_OFF_TABLE_POINTER: rd_mux = {11'h000, tptr};
         IOD_OFF_TBLLAT: rd_mux = {24'h000000, tlat};
         IOD_OFF_STATE: rd_mux = {held, 11'h000, st == ST_SECOND, dec_class};
         default: begin
            for (int i = 0; i < IOD_NUM_PTR; i++) begin
               if (paddr == IOD_OFF_IPTR0 + 8'(4 * i))
                  rd_mux = {20'h00000, iptr[i]};
            end
         end
      endcase
   end

   always_comb begin
      next_pready = psel && penable && !pready;
      next_pslverr = next_pready && !reg_hit(paddr);
      next_prdata = prdata;
      if (next_pready)
         next_prdata = (pwrite || !reg_hit(paddr)) ? 32'h00000000 : rd_mux;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // core: phase counter, two-word capture, register file, decoded controls
   always_comb begin
      next_q = q + 2'h1;
      next_fetch_ready = (next_q == IOD_Q_LAST);
      next_st = st;
      next_held = held;
      next_bank = bank;
      next_alu_flags = alu_flags;
      next_tptr = tptr;
      next_tlat = tlat;
      next_iptr = iptr;
      next_tbl_pend = 1'b0;
      issue = 1'b0;
      next_dec_valid = 1'b0;
      next_dec_opcode = dec_opcode;
      next_dec_class = dec_class;
      next_dec_src_addr = dec_src_addr;
      next_dec_dst_addr = dec_dst_addr;
      next_dec_to_file = dec_to_file;
      next_dec_bit_idx = dec_bit_idx;
      next_dec_literal = dec_literal;
      next_dec_target = dec_target;
      next_dec_rel = dec_rel;
      next_dec_cycles = dec_cycles;
      next_dec_nop = dec_nop;
      next_shadow_save = 1'b0;
      next_shadow_restore = 1'b0;
      next_tbl_rd = 1'b0;
      next_tbl_wr = 1'b0;
      next_tbl_addr = tbl_addr;
      next_tbl_wdata = tbl_wdata;
      if (instr_valid && fetch_ready) begin
         if (st == ST_SECOND) begin
            next_st = ST_FIRST;
            issue = 1'b1;
         end else if (iod_is_double(fld.cls)) begin
            next_held = instr_word;
            next_st = ST_SECOND;
         end else begin
            issue = 1'b1;
         end
      end
      if (bus_wr) begin
         case (paddr)
            IOD_OFF_CTRL: next_bank = pwdata[3:0];
            IOD_OFF_FLAGS: next_alu_flags = pwdata[4:0];
            IOD_OFF_TABLE_POINTER: next_tptr = pwdata[20:0];
            IOD_OFF_TBLLAT: next_tlat = pwdata[7:0];
            default: begin
               for (int i = 0; i < IOD_NUM_PTR; i++) begin
                  if (paddr == IOD_OFF_IPTR0 + 8'(4 * i))
                     next_iptr[i] = pwdata[11:0];
               end
            end
         endcase
      end
      // datapath flag updates override a bus write in the same cycle
      for (int i = 0; i < 5; i++) begin
         if (alu_flag_we[i])
            next_alu_flags[i] = alu_flag_in[i];
      end
      // program memory answers within the strobe cycle
      if (tbl_pend)
         next_tlat = tbl_rdata;
      if (issue) begin
         next_dec_valid = 1'b1;
         next_dec_opcode = fld.first_word;
         next_dec_class = fld.cls;
         next_dec_src_addr = fld.src_addr;
         next_dec_dst_addr = fld.dst_addr;
         next_dec_to_file = fld.to_file;
         next_dec_bit_idx = fld.bit_idx;
         next_dec_literal = fld.literal;
         next_dec_target = fld.target;
         next_dec_rel = fld.rel;
         next_dec_cycles = fld.cycles;
         next_dec_nop = (fld.cls == CL_NOP) || (fld.cls == CL_SECOND);
         case (fld.cls)
            CL_TBLRD, CL_TBLWT: begin
               // pointer moves only for table ops, other classes leave it alone
               next_tbl_addr = (fld.tmode == IOD_TM_PREINC) ? tptr + 21'h000001 : tptr;
               case (fld.tmode)
                  IOD_TM_POSTINC, IOD_TM_PREINC: next_tptr = tptr + 21'h000001;
                  IOD_TM_POSTDEC: next_tptr = tptr - 21'h000001;
                  default: next_tptr = tptr;
               endcase
               next_tbl_rd = (fld.cls == CL_TBLRD);
               next_tbl_wr = (fld.cls == CL_TBLWT);
               next_tbl_pend = (fld.cls == CL_TBLRD);
               next_tbl_wdata = tlat;
            end
            CL_LFSR: begin
               // designator 3 has no pointer behind it and is dropped
               for (int i = 0; i < IOD_NUM_PTR; i++) begin
                  if (fld.ptr_sel == 2'(i))
                     next_iptr[i] = fld.literal[11:0];
               end
            end
            CL_CALL: next_shadow_save = fld.shadow;
            CL_RET: next_shadow_restore = fld.shadow;
            default: next_dec_nop = next_dec_nop;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st <= ST_FIRST;
         q <= 2'h0;
         held <= 16'h0000;
         bank <= IOD_RST_BANK;
         alu_flags <= IOD_RST_FLAGS;
         tptr <= IOD_RST_TP;
         tlat <= IOD_RST_TLAT;
         for (int i = 0; i < IOD_NUM_PTR; i++)
            iptr[i] <= IOD_RST_PTR;
         tbl_pend <= 1'b0;
         fetch_ready <= 1'b0;
         dec_valid <= 1'b0;
         dec_opcode <= 16'h0000;
         dec_class <= 4'h0;
         dec_src_addr <= 12'h000;
         dec_dst_addr <= 12'h000;
         dec_to_file <= 1'b0;
         dec_bit_idx <= 3'h0;
         dec_literal <= 20'h00000;
         dec_target <= 21'h000000;
         dec_rel <= 1'b0;
         dec_cycles <= IOD_CYC_ONE;
         dec_nop <= 1'b0;
         shadow_save <= 1'b0;
         shadow_restore <= 1'b0;
         tbl_rd <= 1'b0;
         tbl_wr <= 1'b0;
         tbl_addr <= IOD_RST_TP;
         tbl_wdata <= IOD_RST_TLAT;
      end else if (ce) begin
         st <= next_st;
         q <= next_q;
         held <= next_held;
         bank <= next_bank;
         alu_flags <= next_alu_flags;
         tptr <= next_tptr;
         tlat <= next_tlat;
         iptr <= next_iptr;
         tbl_pend <= next_tbl_pend;
         fetch_ready <= next_fetch_ready;
         dec_valid <= next_dec_valid;
         dec_opcode <= next_dec_opcode;
         dec_class <= next_dec_class;
         dec_src_addr <= next_dec_src_addr;
         dec_dst_addr <= next_dec_dst_addr;
         dec_to_file <= next_dec_to_file;
         dec_bit_idx <= next_dec_bit_idx;
         dec_literal <= next_dec_literal;
         dec_target <= next_dec_target;
         dec_rel <= next_dec_rel;
         dec_cycles <= next_dec_cycles;
         dec_nop <= next_dec_nop;
         shadow_save <= next_shadow_save;
         shadow_restore <= next_shadow_restore;
         tbl_rd <= next_tbl_rd;
         tbl_wr <= next_tbl_wr;
         tbl_addr <= next_tbl_addr;
         tbl_wdata <= next_tbl_wdata;
      end
   end
endmodule
`default_nettype wire

// *** dv/iod_fetch_model.sv ***
// fetch stage and program memory model
// assumes one send pulse per word
`timescale 1ns/1ps
`default_nettype none
module iod_fetch_model #(
   parameter logic [7:0] TBL_BYTE = 8'hA7
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic send,
   input wire logic [15:0] word,
   input wire logic fetch_ready,
   input wire logic tbl_rd,
   output logic [15:0] instr_word,
   output logic instr_valid,
   output logic taken,
   output logic [7:0] tbl_rdata
);
   // byte answers within the strobe cycle; inverted outside it
   assign tbl_rdata = tbl_rd ? TBL_BYTE : ~TBL_BYTE;
   always_ff @(posedge clk_sys) begin
      taken <= rstn && instr_valid && fetch_ready;
      if (!rstn)
         {instr_valid, instr_word} <= 17'h0;
      else if (send)
         {instr_valid, instr_word} <= {1'h1, word};
      else if (instr_valid && fetch_ready)
         {instr_valid, instr_word} <= {1'h0, ~instr_word};
   end
endmodule
`default_nettype wire

// *** dv/iod_decoder_checker.sv ***
// port assertions for the operand field decoder
// assumes ce held high; bind at the foot
`timescale 1ns/1ps
`default_nettype none
module iod_decoder_checker import iod_pkg::*; #(
   parameter logic [7:0] ACCESS_SPLIT = IOD_ACCESS_SPLIT
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic instr_valid,
   input wire logic fetch_ready,
   input wire logic dec_valid,
   input wire logic [15:0] dec_opcode,
   input wire logic [3:0] dec_class,
   input wire logic [11:0] dec_src_addr,
   input wire logic dec_to_file,
   input wire logic [2:0] dec_bit_idx,
   input wire logic [19:0] dec_literal,
   input wire logic [20:0] dec_target,
   input wire logic dec_rel,
   input wire logic dec_nop,
   input wire logic shadow_save,
   input wire logic shadow_restore,
   input wire logic tbl_rd
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   access_map_a: assert property (dec_valid && dec_class == 4'h1 && !dec_opcode[8] |-> dec_src_addr ==
      {(dec_opcode[7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hF, dec_opcode[7:0]}) else $error("access map");
   bit_index_a: assert property (dec_valid && dec_class == 4'h2 |-> dec_bit_idx == dec_opcode[11:9])
      else $error("bit index");
   dest_sel_a: assert property (dec_valid && dec_class == 4'h1 |-> dec_to_file == dec_opcode[9])
      else $error("destination select");
   shadow_sel_a: assert property (shadow_save || shadow_restore |-> dec_valid &&
      (dec_class == 4'h9 ? dec_opcode[8] : dec_class == 4'hB && dec_opcode[0])) else $error("shadow");
   table_op_a: assert property (tbl_rd |-> dec_valid && dec_class == 4'hC) else $error("table strobe");
   lit_field_a: assert property (dec_valid && dec_class == 4'h3 |-> dec_literal == {12'h000, dec_opcode[7:0]})
      else $error("literal");
   rel_offset_a: assert property (dec_valid && dec_class == 4'h7 |-> dec_rel &&
      dec_target == {{10{dec_opcode[10]}}, dec_opcode[10:0]}) else $error("relative offset");
   lone_second_a: assert property (dec_valid && dec_opcode[15:12] == 4'hF |-> dec_nop) else $error("lone word");
   fetch_cadence_a: assert property (fetch_ready |=> !fetch_ready [*3] ##1 fetch_ready)
      else $error("fetch cadence");
   issue_timing_a: assert property (dec_valid |-> $past(instr_valid) && $past(fetch_ready))
      else $error("issue timing");
   cover property (shadow_save);
   cover property (tbl_rd);
   cover property (dec_valid && dec_nop);
endmodule
bind iod_decoder iod_decoder_checker #(.ACCESS_SPLIT(ACCESS_SPLIT)) u_iod_decoder_checker (
   .clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .fetch_ready(fetch_ready),
   .dec_valid(dec_valid), .dec_opcode(dec_opcode), .dec_class(dec_class), .dec_src_addr(dec_src_addr),
   .dec_to_file(dec_to_file), .dec_bit_idx(dec_bit_idx), .dec_literal(dec_literal), .dec_target(dec_target),
   .dec_rel(dec_rel), .dec_nop(dec_nop), .shadow_save(shadow_save), .shadow_restore(shadow_restore),
   .tbl_rd(tbl_rd));
`default_nettype wire

// *** dv/tb_top.sv ***
// bench for the operand field decoder
// assumes the fetch model feeds words and table bytes
`timescale 1ns/1ps
`default_nettype none
module tb_top import iod_pkg::*;;
   logic clk_sys, rstn, ce, psel, penable, pwrite, pready, pslverr, send, taken, instr_valid, fetch_ready;
   logic dec_valid, dec_to_file, dec_rel, dec_nop, shadow_save, shadow_restore, tbl_rd, tbl_wr;
   logic [7:0] paddr, tbl_rdata, tbl_wdata;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] word, instr_word, dec_opcode;
   logic [4:0] alu_flag_we, alu_flag_in, alu_flags;
   logic [3:0] dec_class;
   logic [11:0] dec_src_addr, dec_dst_addr;
   logic [2:0] dec_bit_idx;
   logic [19:0] dec_literal;
   logic [20:0] dec_target, tbl_addr;
   logic [1:0] dec_cycles, s_rd;
   logic er, s_dv, s_sv, s_rs;
   int bad_count, n_checks, m;
   iod_decoder u_iod_decoder (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_word(instr_word), .instr_valid(instr_valid), .fetch_ready(fetch_ready), .tbl_rdata(tbl_rdata),
      .alu_flag_we(alu_flag_we), .alu_flag_in(alu_flag_in), .alu_flags(alu_flags), .dec_valid(dec_valid),
      .dec_opcode(dec_opcode), .dec_class(dec_class), .dec_src_addr(dec_src_addr), .dec_dst_addr(dec_dst_addr),
      .dec_to_file(dec_to_file), .dec_bit_idx(dec_bit_idx), .dec_literal(dec_literal), .dec_target(dec_target),
      .dec_rel(dec_rel), .dec_cycles(dec_cycles), .dec_nop(dec_nop), .shadow_save(shadow_save),
      .shadow_restore(shadow_restore), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
      .tbl_wdata(tbl_wdata));
   iod_fetch_model u_iod_fetch_model (.clk_sys(clk_sys), .rstn(rstn), .send(send),
      .word(word), .fetch_ready(fetch_ready), .tbl_rd(tbl_rd), .instr_word(instr_word),
      .instr_valid(instr_valid), .taken(taken), .tbl_rdata(tbl_rdata));
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task tmo;
      chk("timeout", 32'h0, 32'h1);
      give_verdict();
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
      @(posedge clk_sys);
      penable <= 1'h1;
      for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge clk_sys);
      if (i == 20) tmo();
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk("apb read", rd, e);
   endtask
   task send_word(input logic [15:0] w);
      int i;
      @(posedge clk_sys);
      {word, send} <= {w, 1'h1};
      @(posedge clk_sys);
      send <= 1'h0;
      for (i = 0; i < 20 && taken !== 1'h1; i++) @(posedge clk_sys);
      if (i == 20) tmo();
      {s_dv, s_sv, s_rs, s_rd} = {dec_valid, shadow_save, shadow_restore, tbl_rd, tbl_wr};
   endtask
   task dec(input logic [15:0] w1, input logic [15:0] w2, input logic dbl);
      send_word(w1);
      if (dbl) send_word(w2);
      chk("issue", s_dv, 1'h1);
   endtask
   initial begin
      {ce, rstn, psel, penable, pwrite, send, paddr, pwdata, word} = {2'h2, 4'h0, 8'h00, 32'h0, 16'h0};
      {alu_flag_we, alu_flag_in, bad_count, n_checks} = {10'h000, 64'h0};
      repeat (16) @(posedge clk_sys);
      rstn <= 1'h1;
      for (m = 0; m < 32; m += 4) rchk(8'(m), 32'h0);
      apb(1'h0, 8'h20, 32'h0);
      chk("unmapped err", er, 1'h1);
      apb(1'h1, IOD_OFF_STATE, 32'hFFFFFFFF);
      rchk(IOD_OFF_STATE, 32'h0);
      $display("test registers done");
      apb(1'h1, IOD_OFF_CTRL, 32'h5);
      dec(16'h2733, 16'h0, 1'h0);
      chk("banked", {dec_to_file, dec_src_addr}, 13'h1533);
      dec({8'h24, IOD_ACCESS_SPLIT - 8'h01}, 16'h0, 1'h0);
      chk("low ram", {dec_to_file, dec_src_addr}, {5'h00, IOD_ACCESS_SPLIT - 8'h01});
      dec({8'h24, IOD_ACCESS_SPLIT}, 16'h0, 1'h0);
      chk("sfr", dec_src_addr, {4'hF, IOD_ACCESS_SPLIT});
      for (m = 0; m < 8; m++) begin
         dec({4'h8, m[2:0], 9'h112}, 16'h0, 1'h0);
         chk("bit idx", dec_bit_idx, m[2:0]);
      end
      $display("test byte and bit done");
      dec(16'h0EA5, 16'h0, 1'h0);
      chk("literal", dec_literal, 20'hA5);
      dec(16'h08A5, 16'h0, 1'h0);
      chk("dont care", dec_class, 4'h3);
      dec(16'hC123, 16'hF456, 1'h1);
      chk("mv src", dec_src_addr, 12'h123);
      chk("mv dst", {dec_cycles, dec_dst_addr}, 14'h2456);
      dec(16'hEE1A, 16'hF0BC, 1'h1);
      rchk(8'h14, 32'hABC);
      apb(1'h1, 8'h18, 32'h200);
      dec(16'hEB05, 16'hF00A, 1'h1);
      chk("idx src", dec_src_addr, 12'h205);
      chk("idx dst", dec_dst_addr, 12'h20A);
      for (m = 0; m < 2; m++) begin
         dec({7'h76, m[0], 8'h12}, 16'hF345, 1'h1);
         chk("call", dec_target, 21'h34512);
         chk("save", s_sv, m[0]);
         dec({15'h0009, m[0]}, 16'h0, 1'h0);
         chk("restore", s_rs, m[0]);
      end
      dec(16'hD7FF, 16'h0, 1'h0);
      chk("branch", dec_target, 21'h1FFFFF);
      dec(16'hF123, 16'h0, 1'h0);
      chk("lone", dec_nop, 1'h1);
      $display("test literal and control done");
      for (m = 0; m < 4; m++) begin
         apb(1'h1, IOD_OFF_TABLE_POINTER, 32'h100);
         dec({14'h0002, m[1:0]}, 16'h0, 1'h0);
         chk("tbl rd", s_rd, 2'h2);
         chk("tbl addr", tbl_addr, (m == 3) ? 21'h101 : 21'h100);
         rchk(IOD_OFF_TABLE_POINTER, (m == 0) ? 32'h100 : (m == 2) ? 32'hFF : 32'h101);
         rchk(IOD_OFF_TBLLAT, 32'hA7);
      end
      dec(16'h000C, 16'h0, 1'h0);
      chk("tbl wr", {s_rd, tbl_wdata}, 10'h1A7);
      apb(1'h1, IOD_OFF_FLAGS, 32'h1F);
      alu_flag_we <= 5'h05;
      @(posedge clk_sys);
      alu_flag_we <= 5'h00;
      rchk(IOD_OFF_FLAGS, 32'h1A);
      chk("flags", alu_flags, 5'h1A);
      $display("test table and flags done");
      give_verdict();
   end
endmodule
`default_nettype wire
